// file: logic/plr_label_regs.sv
// module: partition label registers, access checks and request labels
`timescale 1ns/100ps
`default_nettype none

module plr_label_regs
  import plr_pkg::*;
#(
  parameter bit HAS_TOP_LEVEL = 1'b1,
  parameter bit HAS_SEC_DEFAULT = 1'b1,
  parameter bit HAS_FORCE_NONSECURE_LABEL = 1'b1,
  parameter bit NS_ZERO_SUPPORTED = 1'b1,
  parameter bit VIRT_SUPPORTED = 1'b1
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_op0,
  input wire logic [2:0] acc_op1,
  input wire logic [3:0] acc_crn,
  input wire logic [3:0] acc_crm,
  input wire logic [2:0] acc_op2,
  input wire logic [63:0] acc_wdata,
  input wire logic [1:0] cur_level,
  input wire logic secure_state,
  input wire logic hyp_enabled,
  input wire logic host_extension_mode,
  input wire logic [2:0] nested_virt_control,
  input wire logic halted,
  input wire logic secure_debug_disable,
  input wire logic [63:0] kernel_label_in,
  output logic kernel_label_we,
  output logic [63:0] kernel_label_wdata,
  output logic acc_done,
  output logic [2:0] acc_outcome,
  output logic [5:0] acc_class,
  output logic [63:0] acc_rdata,
  output logic [11:0] virt_mem_offset,
  output logic [15:0] instr_partition_id,
  output logic [7:0] instr_monitor_group,
  output logic [15:0] data_partition_id,
  output logic [7:0] data_monitor_group,
  output logic request_nonsecure_label
);

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // the kernel label fields live outside; only the shared enable lives here
  // reset loads known values, all zero but the lower-level trap bit, which resets to 1, so every run starts the same way
  logic global_label_enable;
  logic lower_level_trap;
  logic secure_default_partition;
  logic force_nonsecure_label;
  logic kernel_reg_trap;
  logic [LABEL_W-1:0] hyp_label;
  logic [LABEL_W-1:0] top_label;
  // only the two map enables are kept; other control bits read zero
  logic [63:0] vcr;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire logic enc_common = (acc_op0 == ENC_OP0) && (acc_crn == ENC_CRN) && (acc_op2 == ENC_OP2);
  wire logic hit_kernel = enc_common && (acc_crm == ENC_CRM) && (acc_op1 == ENC_OP1_KERNEL);
  wire logic hit_hyp = enc_common && (acc_crm == ENC_CRM) && (acc_op1 == ENC_OP1_HYP);
  wire logic hit_top = enc_common && (acc_crm == ENC_CRM) && (acc_op1 == ENC_OP1_TOP);
  wire logic hit_vcr = enc_common && (acc_crm == ENC_CRM_VCR) && (acc_op1 == ENC_OP1_VCR);
  wire logic hit_any = hit_kernel | hit_hyp | hit_top | hit_vcr;
  wire logic is_app = (cur_level == LVL_APP);
  wire logic is_kernel = (cur_level == LVL_KERNEL);
  wire logic is_hyp = (cur_level == LVL_HYP);
  wire logic is_top = (cur_level == LVL_TOP);
  // the trap bit only counts where a top level is built
  wire logic top_trap = HAS_TOP_LEVEL && lower_level_trap;
  wire logic top_trap_undef = halted && secure_debug_disable;
  // nested control bits are {nv2, nv1, nv}
  wire logic nv_all = (nested_virt_control == 3'b111);
  wire logic nv_bit = nested_virt_control[0];
  wire logic vcr_nv = (nested_virt_control[2] & nested_virt_control[0]);

  // redirect of the kernel encoding at hypervisor level
  wire logic kernel_to_hyp = is_hyp && host_extension_mode;

  // combined view of the enable bit; one flop serves all three registers
  wire logic [63:0] hyp_view = {global_label_enable, 14'h0, kernel_reg_trap, hyp_label};
  wire logic ns_view = HAS_FORCE_NONSECURE_LABEL && (force_nonsecure_label || !NS_ZERO_SUPPORTED);
  wire logic [63:0] top_view = {global_label_enable, lower_level_trap,
    HAS_SEC_DEFAULT && secure_default_partition, ns_view, 12'h000, top_label};
  wire logic [63:0] kernel_view = {global_label_enable, kernel_label_in[62:0]};

  // ----------------------------------------
  // access checks
  // ----------------------------------------
  logic [2:0] next_outcome;
  logic [63:0] next_rdata;
  // first matching arm wins, so top-level traps come ahead of hypervisor traps
  always_comb
  begin
    next_outcome = OUT_DONE;
    next_rdata = 64'h0;
    if (is_app)
      next_outcome = OUT_UNDEF;
    else if (hit_top)
    begin
      if (!is_top)
        next_outcome = OUT_UNDEF;
      else
        next_rdata = top_view;
    end
    else if (hit_vcr && !VIRT_SUPPORTED)
      next_outcome = OUT_UNDEF;
    else if (hit_hyp || hit_vcr)
    begin
      if (is_kernel)
      begin
        if (hit_vcr && hyp_enabled && vcr_nv)
          next_outcome = OUT_VIRT_MEM;
        else if (!(hyp_enabled && nv_bit))
          next_outcome = OUT_UNDEF;
        else if (top_trap)
          next_outcome = top_trap_undef ? OUT_UNDEF : OUT_TRAP_TOP;
        else
          next_outcome = OUT_TRAP_HYP;
      end
      else if (is_hyp && top_trap)
        next_outcome = top_trap_undef ? OUT_UNDEF : OUT_TRAP_TOP;
      else
        next_rdata = hit_vcr ? vcr : hyp_view;
    end
    else if (hit_kernel)
    begin
      if (!is_top && top_trap)
        next_outcome = top_trap_undef ? OUT_UNDEF : OUT_TRAP_TOP;
      else if (is_kernel && hyp_enabled && kernel_reg_trap)
        next_outcome = OUT_TRAP_HYP;
      else if (is_kernel && hyp_enabled && nv_all)
        next_outcome = OUT_VIRT_MEM;
      else if (kernel_to_hyp)
        next_rdata = hyp_view;
      else
        next_rdata = kernel_view;
    end
  end

  wire logic take = clk_en && acc_valid && hit_any;
  wire logic do_write = take && acc_write && (next_outcome == OUT_DONE);
  wire logic wr_top = do_write && hit_top;
  wire logic wr_vcr = do_write && hit_vcr;
  wire logic wr_hyp = do_write && (hit_hyp || (hit_kernel && kernel_to_hyp));
  // the kernel fields sit outside, so this strobes the write out and, without the top level, also writes the enable
  wire logic wr_kernel = do_write && hit_kernel && !kernel_to_hyp;
  // without the top level, the hypervisor and kernel views write the enable
  wire logic wr_enable = wr_top || (!HAS_TOP_LEVEL && (wr_hyp || wr_kernel));
  // only the kernel register has a memory slot; the control register redirect reports 0
  wire logic virt_slot = (next_outcome == OUT_VIRT_MEM) && hit_kernel;
  wire logic is_trap = (next_outcome == OUT_TRAP_TOP) || (next_outcome == OUT_TRAP_HYP);
  wire logic [5:0] next_class = is_trap ? TRAP_CLASS : 6'h00;
  wire logic [11:0] next_offset = virt_slot ? VIRT_SLOT_OFFSET : 12'h000;
  wire logic [63:0] next_answer = acc_write ? 64'h0 : next_rdata;

  // ----------------------------------------
  // register updates
  // ----------------------------------------
  // every write is gated by take, so a low clk_en freezes the storage too
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      global_label_enable <= 1'b0;
      lower_level_trap <= 1'b1;
      secure_default_partition <= 1'b0;
      force_nonsecure_label <= 1'b0;
      kernel_reg_trap <= 1'b0;
      hyp_label <= LABEL_RESET;
      top_label <= LABEL_RESET;
      vcr <= VCR_RESET;
    end
    else
    begin
      if (wr_enable)
        global_label_enable <= acc_wdata[BIT_ENABLE];
      if (wr_top)
      begin
        lower_level_trap <= acc_wdata[BIT_TRAP_LOWER];
        secure_default_partition <= HAS_SEC_DEFAULT && acc_wdata[BIT_SEC_DEFAULT];
        force_nonsecure_label <= HAS_FORCE_NONSECURE_LABEL && acc_wdata[BIT_FORCE_NONSECURE_LABEL];
        top_label <= acc_wdata[LABEL_W-1:0];
      end
      if (wr_hyp)
      begin
        kernel_reg_trap <= acc_wdata[BIT_KERNEL_TRAP];
        hyp_label <= acc_wdata[LABEL_W-1:0];
      end
      if (wr_vcr)
        vcr <= {62'h0, acc_wdata[BIT_KERNEL_VMAP], acc_wdata[BIT_APP_VMAP]};
    end
  end

  // ----------------------------------------
  // access answer
  // ----------------------------------------
  // outcome, class, data and offset stand until the next accepted access
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      acc_done <= 1'b0;
      acc_outcome <= OUT_DONE;
      acc_class <= 6'h00;
      acc_rdata <= 64'h0;
      virt_mem_offset <= 12'h000;
      kernel_label_we <= 1'b0;
      kernel_label_wdata <= 64'h0;
    end
    else if (clk_en)
    begin
      acc_done <= take;
      kernel_label_we <= wr_kernel;
      if (take)
      begin
        acc_outcome <= next_outcome;
        acc_class <= next_class;
        acc_rdata <= next_answer;
        virt_mem_offset <= next_offset;
        kernel_label_wdata <= acc_wdata;
      end
    end
  end

  // ----------------------------------------
  // request labels
  // ----------------------------------------
  // source picked from live registers each cycle; nothing held per translation
  logic [LABEL_W-1:0] src_label;
  always_comb
  begin
    case (cur_level)
      LVL_TOP: src_label = top_label;
      LVL_HYP: src_label = hyp_label;
      default: src_label = kernel_label_in[LABEL_W-1:0];
    endcase
  end
  wire logic use_default = !global_label_enable;
  wire logic sec_zero = secure_state && HAS_SEC_DEFAULT && secure_default_partition;
  // secure default only clears partition ids; monitor groups still follow the register
  wire logic pid_zero = use_default || sec_zero;
  wire logic [15:0] next_instr_pid = pid_zero ? DEFAULT_PARTID : src_label[15:0];
  wire logic [15:0] next_data_pid = pid_zero ? DEFAULT_PARTID : src_label[31:16];
  wire logic [7:0] next_instr_pmg = use_default ? DEFAULT_PMG : src_label[39:32];
  wire logic [7:0] next_data_pmg = use_default ? DEFAULT_PMG : src_label[47:40];
  // non-secure state always labels non-secure; only secure state looks at the force bit
  wire logic next_ns = secure_state ? ns_view : 1'b1;

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      instr_partition_id <= DEFAULT_PARTID;
      data_partition_id <= DEFAULT_PARTID;
      instr_monitor_group <= DEFAULT_PMG;
      data_monitor_group <= DEFAULT_PMG;
      request_nonsecure_label <= 1'b0;
    end
    else if (clk_en)
    begin
      instr_partition_id <= next_instr_pid;
      data_partition_id <= next_data_pid;
      instr_monitor_group <= next_instr_pmg;
      data_monitor_group <= next_data_pmg;
      request_nonsecure_label <= next_ns;
    end
  end

endmodule : plr_label_regs
`default_nettype wire

// file: pkg/plr_pkg.sv
// package: constants for the partition label register block
package plr_pkg;

  // ----------------------------------------
  // privilege levels
  // ----------------------------------------
  localparam logic [1:0] LVL_APP = 2'h0;
  localparam logic [1:0] LVL_KERNEL = 2'h1;
  localparam logic [1:0] LVL_HYP = 2'h2;
  localparam logic [1:0] LVL_TOP = 2'h3;

  // ----------------------------------------
  // register encodings
  // ----------------------------------------
  localparam logic [1:0] ENC_OP0 = 2'h3;
  localparam logic [3:0] ENC_CRN = 4'ha;
  localparam logic [3:0] ENC_CRM = 4'h5;
  localparam logic [2:0] ENC_OP2 = 3'h0;
  localparam logic [2:0] ENC_OP1_KERNEL = 3'h0;
  localparam logic [2:0] ENC_OP1_HYP = 3'h4;
  localparam logic [2:0] ENC_OP1_TOP = 3'h6;
  localparam logic [2:0] ENC_OP1_VCR = 3'h4;
  localparam logic [3:0] ENC_CRM_VCR = 4'h4;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_ENABLE = 63;
  localparam int BIT_TRAP_LOWER = 62;
  localparam int BIT_SEC_DEFAULT = 61;
  localparam int BIT_FORCE_NONSECURE_LABEL = 60;
  localparam int BIT_KERNEL_TRAP = 48;
  localparam int BIT_APP_VMAP = 0;
  localparam int BIT_KERNEL_VMAP = 1;
  localparam int LABEL_W = 48;

  // ----------------------------------------
  // outcomes, reset values, other numbers
  // ----------------------------------------
  localparam logic [5:0] TRAP_CLASS = 6'h18;
  localparam logic [11:0] VIRT_SLOT_OFFSET = 12'h900;
  localparam logic [15:0] DEFAULT_PARTID = 16'h0000;
  localparam logic [7:0] DEFAULT_PMG = 8'h00;
  localparam logic [47:0] LABEL_RESET = 48'h0;
  localparam logic [63:0] VCR_RESET = 64'h0;

  typedef enum logic [2:0]
  {
    OUT_DONE = 3'b000,
    OUT_UNDEF = 3'b001,
    OUT_TRAP_TOP = 3'b010,
    OUT_TRAP_HYP = 3'b011,
    OUT_VIRT_MEM = 3'b100
  } plr_outcome_e;

endpackage : plr_pkg

// file: verif/plr_label_regs_checker.sv
// checker: port-level assertions for the partition label registers
`timescale 1ns/100ps
`default_nettype none
module plr_label_regs_checker
  import plr_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic acc_valid,
  input wire logic acc_write,
  input wire logic [1:0] acc_op0,
  input wire logic [2:0] acc_op1,
  input wire logic [3:0] acc_crn,
  input wire logic [3:0] acc_crm,
  input wire logic [2:0] acc_op2,
  input wire logic [1:0] cur_level,
  input wire logic secure_state,
  input wire logic halted,
  input wire logic secure_debug_disable,
  input wire logic acc_done,
  input wire logic [2:0] acc_outcome,
  input wire logic [5:0] acc_class,
  input wire logic [63:0] acc_rdata,
  input wire logic [11:0] virt_mem_offset,
  input wire logic request_nonsecure_label
);
  wire base = acc_op0 == ENC_OP0 && acc_crn == ENC_CRN && acc_op2 == ENC_OP2;
  wire lbl = acc_crm == ENC_CRM && acc_op1 inside {ENC_OP1_TOP, ENC_OP1_HYP, ENC_OP1_KERNEL};
  wire vcr = acc_crm == ENC_CRM_VCR && acc_op1 == ENC_OP1_VCR;
  wire take = clk_en && acc_valid && base && (lbl || vcr);
  wire top = acc_crm == ENC_CRM && acc_op1 == ENC_OP1_TOP;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    take;
  endsequence
  sequence s_trap_done;
    acc_done && (acc_outcome == OUT_TRAP_TOP || acc_outcome == OUT_TRAP_HYP);
  endsequence
  a_done_next: assert property (s_take |=> acc_done)
    else $error("accepted access got no answer");
  a_no_stray: assert property (clk_en && !take |=> !acc_done)
    else $error("answer without accepted access");
  a_app_undef: assert property (take && cur_level == LVL_APP |=> acc_outcome == OUT_UNDEF)
    else $error("application level access not undefined");
  a_top_lower: assert property (take && top && cur_level != LVL_TOP
    |=> acc_outcome == OUT_UNDEF)
    else $error("lower level reached top register");
  a_trap_class: assert property (s_trap_done |-> acc_class == TRAP_CLASS)
    else $error("trap with wrong class");
  a_halt_undef: assert property (take && halted && secure_debug_disable
    |=> acc_outcome != OUT_TRAP_TOP)
    else $error("trap to top while halted with debug disabled");
  a_top_done: assert property (take && cur_level == LVL_TOP |=> acc_outcome == OUT_DONE)
    else $error("top level access not completed");
  a_write_rdata: assert property (take && acc_write |=> acc_rdata == 64'h0)
    else $error("read data not zero on write");
  a_slot_offset: assert property (acc_done && acc_outcome == OUT_VIRT_MEM
    && $past(acc_op1) == ENC_OP1_KERNEL |-> virt_mem_offset == VIRT_SLOT_OFFSET)
    else $error("redirect slot offset wrong");
  a_vcr_slot: assert property (acc_done && acc_outcome == OUT_VIRT_MEM
    && $past(acc_op1) == ENC_OP1_VCR |-> virt_mem_offset == 12'h000)
    else $error("control register redirect offset not zero");
  a_ns_label: assert property (clk_en && !secure_state |=> request_nonsecure_label)
    else $error("non-secure label not set outside secure state");
endmodule : plr_label_regs_checker
bind plr_label_regs plr_label_regs_checker plr_label_regs_checker_inst (.*);
`default_nettype wire

// file: verif/tb.sv
// testbench: directed scenarios for the partition label registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb;
  import plr_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, acc_valid = 1'b0, acc_write = 1'b0, secure_state = 1'b0;
  logic hyp_enabled = 1'b0, host_extension_mode = 1'b0, halted = 1'b0, secure_debug_disable = 1'b0;
  logic [2:0] acc_op1 = 3'h0, nested_virt_control = 3'h0;
  logic [3:0] acc_crm = 4'h5;
  logic [63:0] acc_wdata = 64'h0;
  logic [1:0] cur_level = 2'h3;
  logic clk_en = 1'b1;
  logic [1:0] acc_op0 = ENC_OP0;
  logic [3:0] acc_crn = ENC_CRN;
  logic [2:0] acc_op2 = ENC_OP2;
  logic [63:0] kernel_label_in = 64'h0;
  logic kernel_label_we, acc_done, request_nonsecure_label;
  logic [63:0] kernel_label_wdata, acc_rdata;
  logic [2:0] acc_outcome;
  logic [5:0] acc_class;
  logic [11:0] virt_mem_offset;
  logic [15:0] instr_partition_id, data_partition_id;
  logic [7:0] instr_monitor_group, data_monitor_group;
  int n_errors = 0;
  int check_count = 0;
  always #25 mclk = ~mclk;
  // encoding fields, clock enable and the kernel register image are driven per scenario
  plr_label_regs plr_label_regs_inst (.*);
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task stop_test;
    if (n_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  // answer is fixed at one cycle, so the task returns with it standing
  task automatic acc(input logic w, input logic [1:0] lv, input logic [2:0] op1,
    input logic [63:0] wd);
    @(negedge mclk);
    acc_valid = 1'b1;
    acc_write = w;
    cur_level = lv;
    acc_op1 = op1;
    acc_wdata = wd;
    @(negedge mclk);
    acc_valid = 1'b0;
  endtask : acc
  task automatic chk_out(input logic [2:0] oc, input logic [5:0] cl);
    `CHK("done", 1'b1, acc_done)
    `CHK("outcome", oc, acc_outcome)
    `CHK("class", cl, acc_class)
  endtask : chk_out
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_reset;
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("top reset", 64'h4000_0000_0000_0000, acc_rdata)
    `CHK("pid off", 16'h0, data_partition_id)
    `CHK("pmg off", 8'h0, instr_monitor_group)
  endtask : t_reset
  task t_refuse;
    acc(1'b0, LVL_APP, ENC_OP1_HYP, 64'h0);
    chk_out(OUT_UNDEF, 6'h0);
    acc(1'b0, LVL_KERNEL, ENC_OP1_KERNEL, 64'h0);
    chk_out(OUT_TRAP_TOP, TRAP_CLASS);
    halted = 1'b1;
    secure_debug_disable = 1'b1;
    acc(1'b1, LVL_HYP, ENC_OP1_HYP, 64'hf);
    chk_out(OUT_UNDEF, 6'h0);
    halted = 1'b0;
    acc(1'b1, LVL_HYP, ENC_OP1_TOP, 64'h8000_0000_0000_0000);
    chk_out(OUT_UNDEF, 6'h0);
    acc_crm = 4'h0;
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("unmapped", 1'b0, acc_done)
    acc_crm = 4'h5;
    acc_op2 = 3'h1;
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("op2 miss", 1'b0, acc_done)
    acc_op2 = ENC_OP2;
  endtask : t_refuse
  task t_top_wr;
    acc(1'b1, LVL_TOP, ENC_OP1_TOP, 64'h8fff_aabb_cccc_dddd);
    chk_out(OUT_DONE, 6'h0);
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("top rd", 64'h8000_aabb_cccc_dddd, acc_rdata)
    `CHK("top dpmg", 8'haa, data_monitor_group)
    `CHK("top ipid", 16'hdddd, instr_partition_id)
  endtask : t_top_wr
  task t_redirect;
    hyp_enabled = 1'b1;
    nested_virt_control = 3'h7;
    acc(1'b1, LVL_KERNEL, ENC_OP1_KERNEL, 64'h8000_0000_0000_0005);
    chk_out(OUT_VIRT_MEM, 6'h0);
    `CHK("slot", 12'h900, virt_mem_offset)
    nested_virt_control = 3'h0;
    acc(1'b1, LVL_KERNEL, ENC_OP1_KERNEL, 64'h8000_0000_0000_0005);
    `CHK("kwe", 1'b1, kernel_label_we)
    `CHK("kwdata", 64'h8000_0000_0000_0005, kernel_label_wdata)
  endtask : t_redirect
  task t_hyp;
    acc(1'b1, LVL_TOP, ENC_OP1_HYP, 64'h0001_1122_3344_5566);
    acc(1'b0, LVL_HYP, ENC_OP1_HYP, 64'h0);
    `CHK("hyp rd", 64'h8001_1122_3344_5566, acc_rdata)
    `CHK("hyp dpid", 16'h3344, data_partition_id)
    `CHK("hyp ipmg", 8'h22, instr_monitor_group)
    acc(1'b0, LVL_KERNEL, ENC_OP1_KERNEL, 64'h0);
    chk_out(OUT_TRAP_HYP, TRAP_CLASS);
    nested_virt_control = 3'h1;
    acc(1'b0, LVL_KERNEL, ENC_OP1_HYP, 64'h0);
    chk_out(OUT_TRAP_HYP, TRAP_CLASS);
    nested_virt_control = 3'h0;
    acc(1'b0, LVL_KERNEL, ENC_OP1_HYP, 64'h0);
    chk_out(OUT_UNDEF, 6'h0);
  endtask : t_hyp
  task t_host;
    host_extension_mode = 1'b1;
    acc(1'b1, LVL_HYP, ENC_OP1_KERNEL, 64'h0000_0000_0000_0077);
    `CHK("no kwe", 1'b0, kernel_label_we)
    acc(1'b0, LVL_HYP, ENC_OP1_HYP, 64'h0);
    `CHK("host rd", 64'h8000_0000_0000_0077, acc_rdata)
    host_extension_mode = 1'b0;
  endtask : t_host
  task t_secure;
    secure_state = 1'b1;
    acc(1'b1, LVL_TOP, ENC_OP1_TOP, 64'ha000_aabb_cccc_dddd);
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("sdef pid", 16'h0, data_partition_id)
    `CHK("ns clear", 1'b0, request_nonsecure_label)
    acc(1'b1, LVL_TOP, ENC_OP1_TOP, 64'h9000_aabb_cccc_dddd);
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("ns force", 1'b1, request_nonsecure_label)
    `CHK("sec ipid", 16'hdddd, instr_partition_id)
  endtask : t_secure
  task t_kernel;
    kernel_label_in = 64'h0000_5a6b_7c8d_9e0f;
    acc(1'b0, LVL_KERNEL, ENC_OP1_KERNEL, 64'h0);
    chk_out(OUT_DONE, 6'h0);
    `CHK("kern rd", 64'h8000_5a6b_7c8d_9e0f, acc_rdata)
    `CHK("kern dpid", 16'h7c8d, data_partition_id)
    kernel_label_in = 64'h0000_1200_0000_0000;
    acc(1'b0, LVL_KERNEL, ENC_OP1_KERNEL, 64'h0);
    `CHK("kern live", 8'h12, data_monitor_group)
  endtask : t_kernel
  task t_vcr;
    acc_crm = ENC_CRM_VCR;
    acc(1'b1, LVL_HYP, ENC_OP1_VCR, 64'hffff_ffff_ffff_ffff);
    chk_out(OUT_DONE, 6'h0);
    acc(1'b0, LVL_HYP, ENC_OP1_VCR, 64'h0);
    `CHK("vcr rd", 64'h3, acc_rdata)
    nested_virt_control = 3'h5;
    acc(1'b1, LVL_KERNEL, ENC_OP1_VCR, 64'h0);
    chk_out(OUT_VIRT_MEM, 6'h0);
    `CHK("vcr slot", 12'h000, virt_mem_offset)
    nested_virt_control = 3'h0;
    acc_crm = ENC_CRM;
  endtask : t_vcr
  task t_freeze;
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    clk_en = 1'b0;
    acc(1'b1, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("frozen done", 1'b1, acc_done)
    clk_en = 1'b1;
    acc(1'b0, LVL_TOP, ENC_OP1_TOP, 64'h0);
    `CHK("frozen wr", 1'b1, acc_rdata[BIT_ENABLE])
  endtask : t_freeze
  initial
  begin
    repeat (10) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_refuse();
    t_top_wr();
    t_redirect();
    t_hyp();
    t_host();
    t_secure();
    t_kernel();
    t_vcr();
    t_freeze();
    stop_test();
  end
  initial
  begin
    #200000;
    n_errors++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
